// [logic/shd_defs.svh]
// Address map, field positions, reset values and sizes of the shadow data port.
// Assumes nothing; holds definitions only and is included by the design files.
`ifndef SHD_DEFS_SVH
`define SHD_DEFS_SVH

// Sixteen word locations that all reach the receive and transmit data path.
`define SHD_ALIAS_BASE   32'h50001130
`define SHD_ALIAS_LAST   32'h5000116c
// The single alias word this block is named after.
`define SHD_DATA3_ADDR   32'h5000113c
// Control and status words.
`define SHD_CTRL_ADDR    32'h50001180
`define SHD_STATUS_ADDR  32'h50001184

// Control fields.
`define SHD_CTRL_FIFO_BIT 0
`define SHD_CTRL_IR_BIT   1
// Status fields.
`define SHD_STAT_RXV_BIT  0
`define SHD_STAT_OVR_BIT  1
`define SHD_STAT_TX_HOLDING_EMPTY_BIT 5

// Reset values and sizes.
`define SHD_DATA_RESET   8'h00
`define SHD_CTRL_RESET   2'h0
`define SHD_FIFO_DEPTH   16
`define SHD_BYTE_W       8

`endif

// [logic/shd_pkg.sv]
// Types shared by the shadow data port files.
// Assumes the constants in shd_defs.svh for the values behind them.
package shd_pkg;

  // Bus data phase; Gray codes along idle, write, read.
  typedef enum logic [1:0] {
    SHD_PH_IDLE  = 2'h0,
    SHD_PH_WRITE = 2'h1,
    SHD_PH_READ  = 2'h3
  } shd_phase_t;

  // Register selected by an address phase.
  typedef enum logic [1:0] {
    SHD_SEL_NONE  = 2'h0,
    SHD_SEL_ALIAS = 2'h1,
    SHD_SEL_CTRL  = 2'h2,
    SHD_SEL_STAT  = 2'h3
  } shd_sel_t;

  // Software control word.
  typedef struct packed {
    logic ir_mode;
    logic fifo_en;
  } shd_ctrl_t;

  // A byte with its valid qualifier.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } shd_byte_t;

endpackage : shd_pkg

// [logic/shd_fifo.sv]
// Synchronous FIFO with a memory array, used for receive and transmit queues.
// Assumes one clock; push while full is dropped unless a pop frees a slot.
`timescale 1ns/1ns
module shd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Queue control.
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  // Queue state.
  output logic      [WIDTH-1:0] head,
  output logic                  full,
  output logic                  empty
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             do_push;
  logic             do_pop;

  // Step a pointer round the ring.
  function automatic logic [PW-1:0] shd_step(input logic [PW-1:0] p);
    return (int'(p) == DEPTH - 1) ? '0 : PW'(int'(p) + 1);
  endfunction : shd_step

  // A full queue takes a byte only when a pop frees a slot.
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign full    = (int'(count_reg) == DEPTH);
  assign empty   = (count_reg == '0);
  assign head    = mem[rd_ptr_reg];

  // Storage array.
  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) wr_ptr_reg <= shd_step(wr_ptr_reg);
      if (do_pop) rd_ptr_reg <= shd_step(rd_ptr_reg);
      count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule : shd_fifo

// [logic/shd_buf2.sv]
// Two-entry buffer with valid and ready on both sides; outputs come from flops.
// Assumes one clock; a stall by the receiver loses no byte.
`timescale 1ns/1ns
module shd_buf2
  import shd_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Filling side.
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side.
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  logic             skid_valid_reg;
  logic [WIDTH-1:0] skid_data_reg;
  logic             take;
  logic             give;

  assign in_ready = !skid_valid_reg;
  assign take     = in_valid && in_ready;
  assign give     = out_valid && out_ready;

  // Head slot drives the outputs; the skid slot catches a byte during a stall.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid      <= 1'b0;
      out_data       <= '0;
      skid_valid_reg <= 1'b0;
      skid_data_reg  <= '0;
    end else if (!out_valid || give) begin
      out_valid      <= skid_valid_reg || take;
      out_data       <= skid_valid_reg ? skid_data_reg : in_data;
      skid_valid_reg <= skid_valid_reg && take;
      if (skid_valid_reg) skid_data_reg <= in_data;
    end else if (take) begin
      skid_valid_reg <= 1'b1;
      skid_data_reg  <= in_data;
    end
  end

endmodule : shd_buf2

// [logic/shd_data_port.sv]
// Shadow receive and transmit data port behind an AHB-Lite slave.
// Assumes a deserialiser and serialiser on hclk that present and take whole bytes.
`timescale 1ns/1ns
`include "shd_defs.svh"
module shd_data_port
  import shd_pkg::*;
#(
  parameter int RX_DEPTH = `SHD_FIFO_DEPTH,
  parameter int TX_DEPTH = `SHD_FIFO_DEPTH
) (
  // Bus clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Received bytes from the serial and infrared deserialisers.
  input  wire shd_byte_t   ser_rx,
  input  wire shd_byte_t   ir_rx,
  // Bytes to the serialiser, and the output they are routed to.
  output shd_byte_t        tx_out,
  input  wire logic        tx_ready,
  output logic             tx_ir_route
);

  shd_phase_t phase_reg;
  shd_sel_t   sel_reg;
  shd_ctrl_t  ctrl_reg;
  logic       addr_ok;
  shd_sel_t   sel_now;
  logic       rd_alias;
  logic       wr_alias;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       fifo_flush;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic       rx_in_valid;
  logic [7:0] rx_in_byte;
  logic [7:0] rx_hold_reg;
  logic       rx_hold_valid_reg;
  logic [7:0] rxf_head;
  logic       rxf_full;
  logic       rxf_empty;
  logic       rxf_push;
  logic       rxf_pop;
  logic       rx_valid_flag;
  logic       overrun_reg;
  logic       overrun_set;
  logic [7:0] tx_hold_reg;
  logic       tx_hold_full_reg;
  logic [7:0] txf_head;
  logic       txf_full;
  logic       txf_empty;
  logic       txf_push;
  logic       txf_pop;
  logic       tx_holding_empty;
  logic       src_valid;
  logic [7:0] src_byte;
  logic       buf_in_ready;
  logic       drain;
  logic       tx_buf_valid;
  logic [7:0] tx_buf_data;
  logic [31:0] status_word;

  // Map an address onto one of the block's registers.
  function automatic shd_sel_t shd_decode(input logic [31:0] a);
    if (a >= `SHD_ALIAS_BASE && a <= `SHD_ALIAS_LAST) return SHD_SEL_ALIAS;
    if (a == `SHD_CTRL_ADDR) return SHD_SEL_CTRL;
    if (a == `SHD_STATUS_ADDR) return SHD_SEL_STAT;
    return SHD_SEL_NONE;
  endfunction : shd_decode

  // Address phase decode; only the address phase pops the receive side.
  assign addr_ok  = hsel && htrans[1] && hready;
  assign sel_now  = shd_decode(haddr);
  assign rd_alias = addr_ok && !hwrite && (sel_now == SHD_SEL_ALIAS);
  // Writes take effect at the end of their data phase.
  assign wr_alias = (phase_reg == SHD_PH_WRITE) && (sel_reg == SHD_SEL_ALIAS);
  assign wr_ctrl  = (phase_reg == SHD_PH_WRITE) && (sel_reg == SHD_SEL_CTRL);
  assign wr_stat  = (phase_reg == SHD_PH_WRITE) && (sel_reg == SHD_SEL_STAT);
  assign wr_byte  = hwdata[7:0];
  // Switching queue mode empties both FIFOs; the holding bytes and the output buffer keep their contents.
  assign fifo_flush = wr_ctrl && (hwdata[`SHD_CTRL_FIFO_BIT] != ctrl_reg.fifo_en);

  // Bus phase tracking; every transfer completes with no wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= SHD_PH_IDLE;
      sel_reg   <= SHD_SEL_NONE;
    end else if (addr_ok) begin
      phase_reg <= hwrite ? SHD_PH_WRITE : SHD_PH_READ;
      sel_reg   <= sel_now;
    end else begin
      phase_reg <= SHD_PH_IDLE;
      sel_reg   <= SHD_SEL_NONE;
    end
  end

  // Control word: queue mode and infrared routing.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg    <= `SHD_CTRL_RESET;
      tx_ir_route <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.fifo_en <= hwdata[`SHD_CTRL_FIFO_BIT];
        ctrl_reg.ir_mode <= hwdata[`SHD_CTRL_IR_BIT];
      end
      tx_ir_route <= ctrl_reg.ir_mode;
    end
  end

  // Receive source follows the mode: serial input or infrared input.
  assign rx_in_valid = ctrl_reg.ir_mode ? ir_rx.valid : ser_rx.valid;
  assign rx_in_byte  = ctrl_reg.ir_mode ? ir_rx.data : ser_rx.data;

  // Receive FIFO; a push at full without a pop is dropped inside the queue.
  assign rxf_push = ctrl_reg.fifo_en && rx_in_valid;
  assign rxf_pop  = ctrl_reg.fifo_en && rd_alias;

  shd_fifo #(
    .WIDTH (`SHD_BYTE_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .flush     (fifo_flush),
    .push      (rxf_push),
    .push_data (rx_in_byte),
    .pop       (rxf_pop),
    .head      (rxf_head),
    .full      (rxf_full),
    .empty     (rxf_empty)
  );

  // Single receive holding byte; a new byte always wins over an unread one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_hold_reg       <= `SHD_DATA_RESET;
      rx_hold_valid_reg <= 1'b0;
    end else if (!ctrl_reg.fifo_en && rx_in_valid) begin
      rx_hold_reg       <= rx_in_byte;
      rx_hold_valid_reg <= 1'b1;
    end else if (!ctrl_reg.fifo_en && rd_alias) begin
      rx_hold_valid_reg <= 1'b0;
    end
  end

  // Overrun: an unread holding byte lost, or a byte refused by a full FIFO.
  assign overrun_set = rx_in_valid && (ctrl_reg.fifo_en ? (rxf_full && !rxf_pop)
                                                        : (rx_hold_valid_reg && !rd_alias));

  // Sticky overrun; software writes one to clear, and a new event wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_reg <= 1'b0;
    end else if (overrun_set) begin
      overrun_reg <= 1'b1;
    end else if (wr_stat && hwdata[`SHD_STAT_OVR_BIT]) begin
      overrun_reg <= 1'b0;
    end
  end

  // Receive data is only meaningful while this flag is set.
  assign rx_valid_flag = ctrl_reg.fifo_en ? !rxf_empty : rx_hold_valid_reg;
  assign rd_byte       = ctrl_reg.fifo_en ? rxf_head : rx_hold_reg;

  // Transmit FIFO; the queue itself discards a write made while full unless a drain frees a slot.
  assign txf_push = ctrl_reg.fifo_en && wr_alias;
  assign txf_pop  = ctrl_reg.fifo_en && drain;

  shd_fifo #(
    .WIDTH (`SHD_BYTE_W),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .flush     (fifo_flush),
    .push      (txf_push),
    .push_data (wr_byte),
    .pop       (txf_pop),
    .head      (txf_head),
    .full      (txf_full),
    .empty     (txf_empty)
  );

  // Single transmit holding byte; a write while occupied replaces the byte.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_hold_reg      <= `SHD_DATA_RESET;
      tx_hold_full_reg <= 1'b0;
    end else if (!ctrl_reg.fifo_en && wr_alias) begin
      tx_hold_reg      <= wr_byte;
      tx_hold_full_reg <= 1'b1;
    end else if (!ctrl_reg.fifo_en && drain) begin
      tx_hold_full_reg <= 1'b0;
    end
  end

  // Empty flag that software polls before writing.
  assign tx_holding_empty = ctrl_reg.fifo_en ? txf_empty : !tx_hold_full_reg;

  // Feed the output buffer from whichever transmit store is active.
  assign src_valid = ctrl_reg.fifo_en ? !txf_empty : tx_hold_full_reg;
  assign src_byte  = ctrl_reg.fifo_en ? txf_head : tx_hold_reg;
  assign drain     = src_valid && buf_in_ready;

  shd_buf2 #(
    .WIDTH (`SHD_BYTE_W)
  ) u_tx_buf (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (src_valid),
    .in_data   (src_byte),
    .in_ready  (buf_in_ready),
    .out_valid (tx_buf_valid),
    .out_data  (tx_buf_data),
    .out_ready (tx_ready)
  );

  // The buffer's flops drive the outgoing byte as one word, so the struct has a single driver.
  assign tx_out = '{valid: tx_buf_valid, data: tx_buf_data};

  // Status word as software sees it.
  always_comb begin
    status_word                     = 32'h00000000;
    status_word[`SHD_STAT_RXV_BIT]  = rx_valid_flag;
    status_word[`SHD_STAT_OVR_BIT]  = overrun_reg;
    status_word[`SHD_STAT_TX_HOLDING_EMPTY_BIT] = tx_holding_empty;
  end

  // Read data is registered at the address phase and stands through the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      unique case (sel_now)
        SHD_SEL_ALIAS: hrdata <= {24'h000000, rd_byte};
        SHD_SEL_CTRL:  hrdata <= {30'h00000000, ctrl_reg};
        SHD_SEL_STAT:  hrdata <= status_word;
        SHD_SEL_NONE:  hrdata <= 32'h00000000;
      endcase
    end
  end

  // Zero wait states and an OKAY response on every transfer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Checks on the data path.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_alias_read;
    addr_ok && !hwrite && (sel_now == SHD_SEL_ALIAS);
  endsequence

  sequence s_alias_write_nf;
    !ctrl_reg.fifo_en && wr_alias && !fifo_flush;
  endsequence

  a_alias_upper_zero: assert property (s_alias_read |=> hrdata[31:8] == 24'h000000)
    else $error("alias read upper bits not zero");
  a_fifo_head_read: assert property (s_alias_read ##0 ctrl_reg.fifo_en |=> hrdata[7:0] == $past(rxf_head))
    else $error("alias read did not return the FIFO head");
  a_rx_overwrite: assert property (!ctrl_reg.fifo_en && rx_in_valid |=> rx_hold_reg == $past(rx_in_byte))
    else $error("holding byte not overwritten");
  a_ir_source: assert property (ctrl_reg.ir_mode && !ctrl_reg.fifo_en && ir_rx.valid && !wr_ctrl
                                |=> rx_hold_reg == $past(ir_rx.data) && rx_valid_flag)
    else $error("infrared byte not captured");
  a_overrun_hold: assert property (!ctrl_reg.fifo_en && rx_in_valid && rx_hold_valid_reg && !rd_alias
                                   |=> overrun_reg)
    else $error("overwrite did not flag overrun");
  a_rx_full_drop: assert property (ctrl_reg.fifo_en && rxf_full && rx_in_valid && !rxf_pop && !fifo_flush
                                   |=> rxf_full && overrun_reg && $stable(rxf_head))
    else $error("full receive FIFO lost an entry");
  a_tx_write_clears: assert property (s_alias_write_nf |=> !tx_holding_empty && tx_hold_reg == $past(wr_byte))
    else $error("write did not clear the empty flag");
  a_tx_full_drop: assert property (ctrl_reg.fifo_en && txf_full && wr_alias && !txf_pop && !fifo_flush
                                   |=> txf_full && $stable(txf_head))
    else $error("write into full transmit FIFO changed it");
  a_tx_route_follow: assert property ($changed(ctrl_reg.ir_mode) |=> tx_ir_route == $past(ctrl_reg.ir_mode))
    else $error("transmit routing did not follow mode");
  a_tx_fifo_accepts: assert property (ctrl_reg.fifo_en && wr_alias && !txf_full && !fifo_flush |=> !txf_empty)
    else $error("transmit FIFO refused a write with room");

endmodule : shd_data_port

// [test/shd_link_model.sv]
// Behavioural serial link partner: delivers received bytes and takes transmit bytes.
// Assumes the port's hclk domain; strobes change by non-blocking assignment after an edge.
`timescale 1ns/1ns
module shd_link_model
  import shd_pkg::*;
(
  // Clock.
  input  wire logic      hclk,
  // Received byte streams towards the port.
  output shd_byte_t      ser_rx,
  output shd_byte_t      ir_rx,
  // Transmit stream from the port.
  input  wire shd_byte_t tx_out,
  output logic           tx_ready
);
  logic       stall = 1'b0;
  logic [7:0] got[$];

  // Idle streams start at zero, then carry the inverse of the last byte so stale data never looks valid.
  initial begin
    ser_rx = '0;
    ir_rx = '0;
  end

  // One-cycle valid pulse per byte on the chosen stream.
  task automatic send(input logic ir, input logic [7:0] b);
    @(posedge hclk);
    if (ir) ir_rx <= '{valid: 1'b1, data: b};
    else ser_rx <= '{valid: 1'b1, data: b};
    @(posedge hclk);
    ir_rx <= '{valid: 1'b0, data: ~b};
    ser_rx <= '{valid: 1'b0, data: ~b};
  endtask : send

  // Ready follows the stall control; a byte is taken only on valid and ready.
  assign tx_ready = !stall;
  always @(posedge hclk) begin
    if (tx_out.valid === 1'b1 && tx_ready) got.push_back(tx_out.data);
  end
endmodule : shd_link_model

// [test/shd_data_port_tb.sv]
// Self-checking bench for the shadow data port with short receive and transmit queues.
// Assumes the link partner model and the design files compiled before it.
`timescale 1ns/1ns
`include "shd_defs.svh"
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module shd_data_port_tb
  import shd_pkg::*;
;
  localparam int DEPTH = 4;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, tx_ready, tx_ir_route;
  shd_byte_t   ser_rx, ir_rx, tx_out;
  int          n_mismatch, n_compared, cycles;

  // Design under test with shortened queues.
  shd_data_port #(.RX_DEPTH(DEPTH), .TX_DEPTH(DEPTH)) u_shd_data_port (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ser_rx(ser_rx), .ir_rx(ir_rx), .tx_out(tx_out), .tx_ready(tx_ready),
    .tx_ir_route(tx_ir_route));

  // Far side of the data path.
  shd_link_model u_link (
    .hclk(hclk), .ser_rx(ser_rx), .ir_rx(ir_rx), .tx_out(tx_out), .tx_ready(tx_ready));

  // Clock at 4 ns and a hang limit.
  initial hclk = 1'b0;
  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // One single word transfer; address phase held until ready, data taken at the closing edge.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : xfer

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    `CHK(what, exp, rd)
  endtask : rd_chk

  // Reset values, reserved upper bits and an unmapped word.
  task automatic t_reset();
    rd_chk(`SHD_DATA3_ADDR, 32'h0, "alias reset");
    rd_chk(`SHD_STATUS_ADDR, 32'h20, "status reset");
    rd_chk(`SHD_CTRL_ADDR, 32'h0, "ctrl reset");
    rd_chk(32'h50001170, 32'h0, "unmapped");
    `CHK("hreadyout", 1'b1, hreadyout)
    $display("test reset done");
  endtask : t_reset

  // Without queues: one byte is read, then an unread byte is overwritten.
  task automatic t_rx_plain();
    u_link.send(1'b0, 8'h41);
    rd_chk(`SHD_STATUS_ADDR, 32'h21, "rx valid");
    rd_chk(`SHD_DATA3_ADDR, 32'h41, "rx byte");
    u_link.send(1'b0, 8'h5a);
    u_link.send(1'b0, 8'ha5);
    rd_chk(`SHD_STATUS_ADDR, 32'h23, "overrun plain");
    rd_chk(`SHD_DATA3_ADDR, 32'ha5, "overwrite");
    xfer(1'b1, `SHD_STATUS_ADDR, 32'h2);
    rd_chk(`SHD_STATUS_ADDR, 32'h20, "overrun clear");
    $display("test rx plain done");
  endtask : t_rx_plain

  // Infrared mode takes the infrared stream only, on another alias word, and routes transmit.
  task automatic t_ir();
    xfer(1'b1, `SHD_CTRL_ADDR, 32'h2);
    // Routing follows the control word one cycle after it lands.
    repeat (2) @(posedge hclk);
    `CHK("ir route", 1'b1, tx_ir_route)
    u_link.send(1'b0, 8'h11);
    u_link.send(1'b1, 8'hc3);
    rd_chk(`SHD_ALIAS_BASE, 32'hc3, "ir byte");
    rd_chk(`SHD_STATUS_ADDR, 32'h20, "ir drained");
    xfer(1'b1, `SHD_CTRL_ADDR, 32'h0);
    repeat (2) @(posedge hclk);
    `CHK("serial route", 1'b0, tx_ir_route)
    $display("test ir done");
  endtask : t_ir

  // With queues: oldest first, a byte beyond depth is dropped and flags overrun.
  task automatic t_rx_fifo();
    xfer(1'b1, `SHD_CTRL_ADDR, 32'h1);
    for (int i = 0; i <= DEPTH; i++) u_link.send(1'b0, 8'h30 + 8'(i));
    rd_chk(`SHD_STATUS_ADDR, 32'h23, "overrun full");
    for (int i = 0; i < DEPTH; i++) rd_chk(`SHD_ALIAS_LAST, 32'h30 + i, "fifo order");
    rd_chk(`SHD_STATUS_ADDR, 32'h22, "fifo empty");
    xfer(1'b1, `SHD_STATUS_ADDR, 32'h2);
    $display("test rx fifo done");
  endtask : t_rx_fifo

  // Wait for the partner to collect n bytes, bounded.
  task automatic drain(input int n);
    u_link.stall <= 1'b0;
    for (int i = 0; i < 200 && u_link.got.size() < n; i++) @(posedge hclk);
  endtask : drain

  // With queues and a stalled link: writes past the queue and the two-entry output buffer are lost, order kept.
  task automatic t_tx_fifo();
    u_link.got.delete();
    u_link.stall <= 1'b1;
    rd_chk(`SHD_STATUS_ADDR, 32'h20, "tx_holding_empty before");
    for (int i = 0; i < 2 * DEPTH + 2; i++) xfer(1'b1, `SHD_DATA3_ADDR, 32'hffffff10 + i);
    rd_chk(`SHD_STATUS_ADDR, 32'h0, "tx full");
    drain(2 * DEPTH + 2);
    `CHK("kept at least depth", 1'b1, u_link.got.size() >= DEPTH)
    `CHK("late writes lost", DEPTH + 2, u_link.got.size())
    foreach (u_link.got[i]) `CHK("tx order", 8'h10 + 8'(i), u_link.got[i])
    xfer(1'b1, `SHD_CTRL_ADDR, 32'h0);
    $display("test tx fifo done");
  endtask : t_tx_fifo

  // Without queues and a stalled link: the holding byte clears empty and is overwritten.
  task automatic t_tx_plain();
    u_link.got.delete();
    u_link.stall <= 1'b1;
    xfer(1'b1, `SHD_DATA3_ADDR, 32'h61);
    xfer(1'b1, `SHD_DATA3_ADDR, 32'h62);
    xfer(1'b1, `SHD_DATA3_ADDR, 32'h63);
    rd_chk(`SHD_STATUS_ADDR, 32'h0, "tx_holding_empty clear");
    xfer(1'b1, `SHD_DATA3_ADDR, 32'h64);
    drain(3);
    repeat (10) @(posedge hclk);
    `CHK("tx count", 3, u_link.got.size())
    `CHK("tx first", 8'h61, u_link.got[0])
    `CHK("tx overwrite", 8'h64, u_link.got[2])
    rd_chk(`SHD_STATUS_ADDR, 32'h20, "tx_holding_empty set");
    $display("test tx plain done");
  endtask : t_tx_plain

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_rx_plain();
    t_ir();
    t_rx_fifo();
    t_tx_fifo();
    t_tx_plain();
    tally_and_finish();
  end
endmodule : shd_data_port_tb
